// ==== hdl/tcpwm_pkg.sv ====
// constants for the timer/counter/pwm unit: register map, field layout, encodings
// assumes a 32-bit apb slave with byte addresses and one word per register
package tcpwm_pkg;
   localparam int CNT_W = 16;                        // counter width
   localparam int ADDR_W = 6;                        // apb address width
   localparam logic [5:0] OFF_CTRL = 6'h00;          // control register
   localparam logic [5:0] OFF_PERIOD = 6'h04;        // period value
   localparam logic [5:0] OFF_COMPARE = 6'h08;       // compare value
   localparam logic [5:0] OFF_COUNT = 6'h0c;         // live counter, read only
   localparam logic [5:0] OFF_CAPTURE = 6'h10;       // captured value, read only
   localparam logic [5:0] OFF_STATUS = 6'h14;        // sticky events, write one to clear
   localparam logic [5:0] OFF_MASK = 6'h18;          // interrupt mask
   localparam logic [5:0] OFF_DEADBAND = 6'h1c;      // deadband length in counting ticks
   // control fields
   localparam int CTRL_RUN = 0;                      // start counting
   localparam int CTRL_MODE_LO = 1;                  // two-bit run mode
   localparam int CTRL_CMP_LO = 3;                   // three-bit compare mode
   localparam int CTRL_CLK_LO = 6;                   // two-bit clock source
   localparam int CTRL_CTOUT = 8;                    // tc pin carries complementary pwm
   localparam int CTRL_W = 9;
   // status fields
   localparam int ST_TC = 0;
   localparam int ST_CMP = 1;
   localparam int ST_CAP = 2;
   localparam int ST_W = 3;
   localparam logic [CNT_W-1:0] PERIOD_RST = 16'hffff;
   localparam logic [CNT_W-1:0] ZERO_CNT = 16'h0000;
   localparam logic [7:0] DB_RST = 8'h00;
   typedef enum logic [1:0] {
      MODE_FREE = 2'h0, MODE_ONESHOT = 2'h1, MODE_GATED = 2'h2
   } run_mode_e;
   typedef enum logic [2:0] {
      less_than = 3'h0, less_or_equal = 3'h1, same_value = 3'h2,
      greater_or_equal = 3'h3, greater_than = 3'h4
   } cmp_mode_e;
   typedef enum logic [1:0] {
      CLK_SYS = 2'h0, CLK_SRC1 = 2'h1, CLK_SRC2 = 2'h2, CLK_SRC3 = 2'h3
   } clk_sel_e;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001, ST_COUNT = 3'b010, ST_DONE = 3'b100
   } run_state_e;
endpackage

// ==== hdl/timer_counter_pwm_unit.sv ====
// one timer/counter/pwm instance with an apb register slave; the chip holds four
// assumes routed inputs are synchronous to ref_clk; clock sources are tick enables
// Function
// RULE_01: 16-bit counter counting down only
// RULE_02: compare modes lt, le, eq, ge, gt
// RULE_03: reload period on start, reset, terminal count
// RULE_04: selectable interrupt on tc, compare, capture
// RULE_05: one-shot stops at end of period
// RULE_06: gated mode counts only while enable high
// RULE_07: free-run, one-shot or gated modes
// RULE_08: kill forces compare outputs inactive
// RULE_09: capture stores full 16-bit count
// RULE_10: complementary pwm outputs with deadband
// RULE_11: compare, tc and interrupt outputs
// RULE_12: timer reset and capture routed inputs
// RULE_13: counting clock selectable from several sources
// RULE_14: tc one counting tick at zero
// RULE_15: count reads do not disturb counter
//
// The placing of the registers and register access over APB were chosen for this implementation.
module timer_counter_pwm_unit
   import tcpwm_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [tcpwm_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // routed inputs
   input wire logic [2:0] clkSrcTick,
   input wire logic timerReset,
   input wire logic captureIn,
   input wire logic enableIn,
   input wire logic killIn,
   // routed outputs
   output logic compareOut,
   output logic tcOut,
   output logic irq
);
   import tcpwm_pkg::*;

   logic rstSync1_r, rstSync2_r;                // reset release synchroniser
   logic rstn;
   logic [CTRL_W-1:0] ctrl_r;                   // control register
   logic [CNT_W-1:0] period_r, compare_r;       // software values
   logic [CNT_W-1:0] count_r;                   // live counter
   logic [CNT_W-1:0] capture_r;                 // captured count
   logic [ST_W-1:0] status_r, mask_r;           // sticky events and mask
   logic [7:0] deadband_r;                      // deadband ticks
   logic [7:0] dbCnt_r;                         // deadband countdown
   logic run_q;                                 // run bit of previous cycle
   logic capIn_q, cmp_q;                        // edge detection of capture and compare
   logic pwmRaw_q;                              // compare result of previous cycle
   logic tcPulse_r;                             // one-tick terminal count
   logic compareOut_r, tcOut_r, irq_r;
   logic [31:0] prdata_r;
   run_state_e state_r, state_nxt;
   logic tick, cmpTrue, tcHit, startEdge, capEdge, cmpEdge;
   logic cntEn;                                 // one counting step of the live counter
   logic dbClear;                               // outputs may follow the comparator this cycle
   logic wrEn, rdEn;
   logic [ST_W-1:0] events;
   logic [31:0] rdMux;

   // release reset through two flops so the counter, state, output and software registers leave reset together
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rstSync1_r <= 1'b0;
         rstSync2_r <= 1'b0;
      end else begin
         rstSync1_r <= 1'b1;
         rstSync2_r <= rstSync1_r;
      end
   end
   assign rstn = rstSync2_r;

   // zero-wait apb slave: access phase completes in one cycle
   assign wrEn = psel & penable & pwrite;
   assign rdEn = psel & penable & ~pwrite;

   // counting tick from the selected clock source
   // sources arrive as one-cycle enables, never as clocks, so the whole unit
   // stays in the ref_clk domain and no gated clock skews against the bus
   always_comb begin
      case (clk_sel_e'(ctrl_r[CTRL_CLK_LO +: 2]))
         CLK_SYS: tick = 1'b1;
         CLK_SRC1: tick = clkSrcTick[0];
         CLK_SRC2: tick = clkSrcTick[1];
         CLK_SRC3: tick = clkSrcTick[2];
         default: tick = 1'b1;
      endcase
   end // RULE_13

   // comparator against the live count
   // unsigned compare; it runs even while stopped, so a held count still
   // drives the pwm level that firmware last configured
   always_comb begin
      case (cmp_mode_e'(ctrl_r[CTRL_CMP_LO +: 3]))
         less_than: cmpTrue = count_r < compare_r;
         less_or_equal: cmpTrue = count_r <= compare_r;
         same_value: cmpTrue = count_r == compare_r;
         greater_or_equal: cmpTrue = count_r >= compare_r;
         greater_than: cmpTrue = count_r > compare_r;
         default: cmpTrue = 1'b0;
      endcase
   end // RULE_02

   assign startEdge = ctrl_r[CTRL_RUN] & ~run_q;
   // a stopped or gated-off counter neither moves nor reports terminal count;
   // requiring the run bit keeps a stray tc out of the cycle after a stop
   assign cntEn = (state_r == ST_COUNT) & ctrl_r[CTRL_RUN] & tick
      & ((run_mode_e'(ctrl_r[CTRL_MODE_LO +: 2]) != MODE_GATED) | enableIn); // RULE_06 RULE_07
   assign tcHit = cntEn & (count_r == ZERO_CNT);
   assign capEdge = captureIn & ~capIn_q;
   assign cmpEdge = cmpTrue & ~cmp_q;
   assign events = {capEdge, cmpEdge, tcHit}; // RULE_04

   // run state: idle until started, done after a one-shot period
   // a finished one-shot waits in done; firmware clears run and sets it again
   // to restart, which also gives the reload a clean start edge
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: if (startEdge) state_nxt = ST_COUNT;
         ST_COUNT: begin
            if (!ctrl_r[CTRL_RUN]) state_nxt = ST_IDLE;
            else if (tcHit && run_mode_e'(ctrl_r[CTRL_MODE_LO +: 2]) == MODE_ONESHOT)
               state_nxt = ST_DONE; // RULE_05
         end
         ST_DONE: if (!ctrl_r[CTRL_RUN]) state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) state_r <= ST_IDLE;
      else if (!rstn) state_r <= ST_IDLE;
      else state_r <= state_nxt; // RULE_07
   end

   // down counter; reads of the count never touch it
   // a start or a timer reset beats the terminal-count reload in the same cycle;
   // both load the same period, and tcHit fires either way, so the order changes nothing
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         count_r <= PERIOD_RST;
      end else if (!rstn) begin
         count_r <= PERIOD_RST;
      end else if (startEdge || timerReset) begin
         count_r <= period_r; // RULE_03 RULE_12
      end else if (cntEn) begin
         // cntEn already holds the gate, so a low enable keeps the count
         if (count_r == ZERO_CNT) count_r <= period_r; // RULE_03
         else count_r <= count_r - 16'h0001; // RULE_01 RULE_15
      end
   end

   // capture keeps the whole counter on a rising capture input
   // a capture input held high captures once; software sees the value of
   // the cycle in which the edge arrived
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) capture_r <= ZERO_CNT;
      else if (!rstn) capture_r <= ZERO_CNT;
      else if (capEdge) capture_r <= count_r; // RULE_09 RULE_12
   end

   // edge history flops
   // these leave reset with the pin reset only; their inputs are low then,
   // so no false edge follows the internal release
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         run_q <= 1'b0;
         capIn_q <= 1'b0;
         cmp_q <= 1'b0;
         tcPulse_r <= 1'b0;
      end else begin
         run_q <= ctrl_r[CTRL_RUN];
         capIn_q <= captureIn;
         cmp_q <= cmpTrue;
         tcPulse_r <= tcHit; // RULE_14
      end
   end

   // without a deadband the outputs follow the comparator directly, so a
   // one-count equal match still shows; with one, every edge is blanked
   assign dbClear = (deadband_r == DB_RST) | ((dbCnt_r == DB_RST) & (cmpTrue == pwmRaw_q)); // RULE_10

   // deadband: after any pwm edge compareOut, and tcOut when it carries complementary pwm, stay off for deadband ticks
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pwmRaw_q <= 1'b0;
         dbCnt_r <= DB_RST;
      end else if (!rstn) begin
         pwmRaw_q <= 1'b0;
         dbCnt_r <= DB_RST;
      end else begin
         pwmRaw_q <= cmpTrue;
         if (cmpTrue != pwmRaw_q) dbCnt_r <= deadband_r;
         else if (tick && dbCnt_r != DB_RST) dbCnt_r <= dbCnt_r - 8'h01;
      end
   end

   // output flops; kill forces both compare-derived outputs low
   // kill has priority over every mode so a fault shuts the bridge at once;
   // the limitation is one cycle of latency through the output flop
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         compareOut_r <= 1'b0;
         tcOut_r <= 1'b0;
      end else if (killIn || !rstn) begin
         compareOut_r <= 1'b0; // RULE_08
         tcOut_r <= 1'b0;
      end else begin
         compareOut_r <= cmpTrue & dbClear; // RULE_10
         if (ctrl_r[CTRL_CTOUT])
            tcOut_r <= ~cmpTrue & dbClear; // RULE_10
         else
            tcOut_r <= tcHit; // RULE_11
      end
   end

   // software registers; a hardware event beats a same-cycle clear
   // only byte lanes zero and one carry data; the count and capture offsets
   // have no write path, so a write to them is dropped without an error
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_r <= '0;
         period_r <= PERIOD_RST;
         compare_r <= ZERO_CNT;
         mask_r <= '0;
         deadband_r <= DB_RST;
         status_r <= '0;
      end else if (!rstn) begin
         ctrl_r <= '0;
         period_r <= PERIOD_RST;
         compare_r <= ZERO_CNT;
         mask_r <= '0;
         deadband_r <= DB_RST;
         status_r <= '0;
      end else begin
         if (wrEn && pstrb[0]) begin
            case (paddr)
               OFF_CTRL: ctrl_r[7:0] <= pwdata[7:0];
               OFF_PERIOD: period_r[7:0] <= pwdata[7:0];
               OFF_COMPARE: compare_r[7:0] <= pwdata[7:0];
               OFF_MASK: mask_r <= pwdata[ST_W-1:0];
               OFF_DEADBAND: deadband_r <= pwdata[7:0];
               default: ;
            endcase
         end
         if (wrEn && pstrb[1]) begin
            case (paddr)
               OFF_CTRL: ctrl_r[CTRL_W-1] <= pwdata[8];
               OFF_PERIOD: period_r[15:8] <= pwdata[15:8];
               OFF_COMPARE: compare_r[15:8] <= pwdata[15:8];
               default: ;
            endcase
         end
         if (wrEn && pstrb[0] && paddr == OFF_STATUS)
            status_r <= (status_r & ~pwdata[ST_W-1:0]) | events; // RULE_04
         else
            status_r <= status_r | events;
      end
   end

   // read mux; unmapped offsets read zero
   // the mux is taken into a flop at the setup edge, which keeps the
   // counter off the bus path while costing nothing in wait states
   always_comb begin
      case (paddr)
         OFF_CTRL: rdMux = {23'h000000, ctrl_r};
         OFF_PERIOD: rdMux = {16'h0000, period_r};
         OFF_COMPARE: rdMux = {16'h0000, compare_r};
         OFF_COUNT: rdMux = {16'h0000, count_r}; // RULE_15
         OFF_CAPTURE: rdMux = {16'h0000, capture_r};
         OFF_STATUS: rdMux = {29'h00000000, status_r};
         OFF_MASK: rdMux = {29'h00000000, mask_r};
         OFF_DEADBAND: rdMux = {24'h000000, deadband_r};
         default: rdMux = 32'h00000000;
      endcase
   end

   // registered read data and interrupt level
   // irq trails status and mask by one cycle; it stays a plain level so the
   // interrupt controller never has to catch a pulse
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         prdata_r <= 32'h00000000;
         irq_r <= 1'b0;
      end else begin
         if (psel && !penable && !pwrite) prdata_r <= rdMux;
         irq_r <= |(status_r & mask_r); // RULE_11
      end
   end

   assign prdata = prdata_r;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign compareOut = compareOut_r;
   assign tcOut = tcOut_r;
   assign irq = irq_r;
endmodule

// ==== tb/routing_fabric_model.sv ====
// routing fabric model: drives the unit's routed inputs when the bench asks
// assumes callers enter its tasks just after a ref_clk edge
module routing_fabric_model (
   // clock
   input wire logic ref_clk,
   // routed signals toward the unit
   output logic [2:0] clkSrcTick,
   output logic timerReset, captureIn, enableIn, killIn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] div_r = 3'h0; // free divider behind the three tick sources
   initial begin
      {timerReset, captureIn, enableIn, killIn} = '0;
   end
   // tick sources, synchronous to ref_clk: one in four, one in two, one in eight cycles
   always @(posedge ref_clk) begin
      div_r <= div_r + 3'h1;
      clkSrcTick <= {div_r == 3'h7, div_r[0], div_r[1:0] == 2'h3};
   end
   // one-cycle strobe of timer reset or capture
   task automatic strobe(input logic cap);
      @(posedge ref_clk);
      timerReset <= !cap;
      captureIn <= cap;
      @(posedge ref_clk);
      timerReset <= 1'b0;
      captureIn <= 1'b0;
   endtask
   // levels of kill and gate
   task automatic level(input logic k, e);
      @(posedge ref_clk);
      killIn <= k;
      enableIn <= e;
   endtask
endmodule

// ==== tb/tb.sv ====
// self-checking bench for one timer/counter/pwm unit over apb
// assumes the fabric model drives every routed input
module tb import tcpwm_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [5:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q, q2;
   logic pready, pslverr, compareOut, tcOut, irq, timerReset, captureIn, enableIn, killIn;
   logic [2:0] clkSrcTick;
   int fails = 0, cmpCount = 0, cyc = 0, g, nc, nt;
   int expCnt[5] = '{4, 5, 1, 6, 5}; // counts 9..0 matching each mode against 4
   int tickDiv[4] = '{1, 4, 2, 8}; // cycles per tick of clock sources 0..3 in the fabric model
   always #12.5 ref_clk = ~ref_clk;
   timer_counter_pwm_unit dut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .clkSrcTick(clkSrcTick), .timerReset(timerReset), .captureIn(captureIn),
      .enableIn(enableIn), .killIn(killIn), .compareOut(compareOut), .tcOut(tcOut), .irq(irq));
   routing_fabric_model fab (.ref_clk(ref_clk), .clkSrcTick(clkSrcTick), .timerReset(timerReset),
      .captureIn(captureIn), .enableIn(enableIn), .killIn(killIn));
   task automatic conclude();
      if (fails == 0 && cmpCount > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // a hang counts as a mismatch
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         conclude();
      end
   end
   task automatic chk(input logic [31:0] got, exp);
      cmpCount++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one apb transfer; read data lands in q, then one idle cycle
   task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   // highs of both outputs over len cycles
   task automatic tally(input int len);
      nc = 0;
      nt = 0;
      repeat (len) begin
         @(posedge ref_clk);
         nc += int'(compareOut === 1'b1);
         nt += int'(tcOut === 1'b1);
      end
   endtask
   // period of tc at every clock source
   task automatic s_free();
      for (int s = 0; s < 4; s++) begin
         xfer(1, OFF_PERIOD, 32'h5);
         xfer(1, OFF_CTRL, 32'(1 | (s << CTRL_CLK_LO)));
         while (tcOut !== 1'b1) @(posedge ref_clk);
         @(posedge ref_clk);
         for (g = 0; tcOut !== 1'b1; g++) @(posedge ref_clk);
         chk(32'(g), 32'(tickDiv[s] * 6 - 1));
         xfer(1, OFF_CTRL, 32'h0);
      end
   endtask
   // sticky status, mask and clear, then reload and capture
   task automatic s_irq_cap();
      xfer(0, OFF_STATUS, 32'h0);
      chk(32'(q[ST_TC]), 32'h1);
      xfer(1, OFF_MASK, 32'h7);
      repeat (2) @(posedge ref_clk);
      chk(32'(irq), 32'h1);
      xfer(1, OFF_STATUS, 32'h7);
      repeat (2) @(posedge ref_clk);
      chk(32'(irq), 32'h0);
      fab.strobe(0);
      xfer(0, OFF_COUNT, 32'h0);
      chk(q, 32'h5);
      xfer(1, OFF_PERIOD, 32'habcd);
      fab.strobe(0);
      fab.strobe(1);
      xfer(1, OFF_COUNT, 32'h0);
      xfer(0, OFF_CAPTURE, 32'h0);
      chk(q, 32'habcd);
      xfer(0, OFF_COUNT, 32'h0);
      chk(q, 32'habcd);
      chk(32'(irq), 32'h1);
   endtask
   // gated counting holds while enable is low
   task automatic s_gate();
      xfer(1, OFF_CTRL, 32'h5);
      repeat (8) @(posedge ref_clk);
      xfer(0, OFF_COUNT, 32'h0);
      chk(q, 32'habcd);
      fab.level(0, 1);
      repeat (8) @(posedge ref_clk);
      fab.level(0, 0);
      xfer(0, OFF_COUNT, 32'h0);
      q2 = q;
      xfer(0, OFF_COUNT, 32'h0);
      chk(q, q2);
      chk(32'(q < 32'habcd), 32'h1);
      xfer(1, OFF_CTRL, 32'h0);
   endtask
   // one-shot stops after a single tc
   task automatic s_once();
      xfer(1, OFF_PERIOD, 32'h3);
      xfer(1, OFF_CTRL, 32'h3);
      tally(12);
      chk(32'(nt), 32'h1);
      tally(20);
      chk(32'(nt), 32'h0);
      xfer(0, OFF_COUNT, 32'h0);
      chk(q, 32'h3);
      xfer(1, OFF_CTRL, 32'h0);
   endtask
   // every compare mode, then complementary outputs and kill
   task automatic s_pwm();
      xfer(1, OFF_PERIOD, 32'h9);
      xfer(1, OFF_COMPARE, 32'h4);
      for (int m = 0; m < 5; m++) begin
         xfer(1, OFF_CTRL, 32'(1 | (m << CTRL_CMP_LO)));
         @(posedge ref_clk); // skip the cycle that still compares the stale count
         tally(30);
         chk(32'(nc), 32'(3 * expCnt[m]));
         xfer(1, OFF_CTRL, 32'h0);
      end
      xfer(1, OFF_DEADBAND, 32'h2);
      xfer(1, OFF_CTRL, 32'h119);
      tally(30);
      chk(32'(nc > 0 && nt > 0 && nc + nt < 30), 32'h1);
      fab.level(1, 0);
      @(posedge ref_clk);
      tally(10);
      chk(32'(nc + nt), 32'h0);
   endtask
   initial begin
      repeat (5) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge ref_clk);
      xfer(0, OFF_PERIOD, 32'h0);
      chk(q, 32'(PERIOD_RST));
      xfer(0, 6'h24, 32'h0);
      chk(q, 32'h0);
      s_free();
      s_irq_cap();
      s_gate();
      s_once();
      s_pwm();
      conclude();
   end
endmodule

// ==== tb/tcpwm_checker.sv ====
// checker for the timer unit, bound to its top ports
// assumes the bench writes whole words, so the shadows ignore pstrb
module tcpwm_checker
   import tcpwm_pkg::*;
(
   // apb side
   input wire logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr,
   input wire logic [tcpwm_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   // routed side
   input wire logic enableIn, killIn, compareOut, tcOut, irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] ctrl_r; // shadow of the control word
   logic [2:0] mask_r; // shadow of the mask; irq must stay low while it is clear
   // shadows follow completed writes only, so a refused setup never moves them
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_r <= '0;
         mask_r <= '0;
      end else if (psel && penable && pwrite && pready) begin
         if (paddr == OFF_CTRL) ctrl_r <= pwdata[8:0];
         if (paddr == OFF_MASK) mask_r <= pwdata[2:0];
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   property p_ready; pready && !pslverr; endproperty
   a_ready: assert property (p_ready) else $error("apb wait or error seen");
   property p_kill; killIn |=> !compareOut && !tcOut; endproperty
   a_kill: assert property (p_kill) else $error("output active under kill");
   property p_split; ctrl_r[CTRL_CTOUT] |-> !(compareOut && tcOut); endproperty
   a_split: assert property (p_split) else $error("both pwm outputs high");
   property p_hole; psel && !penable && !pwrite && paddr >= 6'h20 |=> prdata == 32'h0; endproperty
   a_hole: assert property (p_hole) else $error("unmapped read not zero");
   property p_tc; !ctrl_r[CTRL_CTOUT] && tcOut |=> !tcOut; endproperty
   a_tc: assert property (p_tc) else $error("tc pulse longer than a cycle");
   property p_once; ctrl_r[2:1] == MODE_ONESHOT && !ctrl_r[CTRL_CTOUT] && tcOut |=> !tcOut [*8]; endproperty
   a_once: assert property (p_once) else $error("one-shot counted on");
   property p_gate; ctrl_r[2:1] == MODE_GATED && !ctrl_r[CTRL_CTOUT] && !enableIn |=> !tcOut; endproperty
   a_gate: assert property (p_gate) else $error("tc while gate low");
   property p_idle; (!ctrl_r[CTRL_RUN] && !ctrl_r[CTRL_CTOUT]) [*2] |-> !tcOut; endproperty
   a_idle: assert property (p_idle) else $error("tc while stopped");
   property p_mask; (mask_r == 3'h0) [*2] |-> !irq; endproperty
   a_mask: assert property (p_mask) else $error("irq with mask clear");
   c_tc: cover property ($rose(tcOut));
   c_irq: cover property ($rose(irq));
   c_kill: cover property (killIn ##1 !compareOut);
endmodule
bind timer_counter_pwm_unit tcpwm_checker chk (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .enableIn(enableIn), .killIn(killIn),
   .compareOut(compareOut), .tcOut(tcOut), .irq(irq));
